// ==== src/asz_host.sv ====
// Host controller driving an asynchronous 4096x4 SRAM with bulk-zero input.
// Assumes a request source on clk_in and the RAM on the pin outputs.
`timescale 1ns/1ps
module asz_host #(
  parameter int unsigned ADDR_W = asz_pkg::ADDR_W,
  parameter int unsigned DATA_W = asz_pkg::DATA_W
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic req_valid_in,
  input wire asz_pkg::asz_req_t req_in,
  output logic req_ready_out,
  output logic rsp_valid_out,
  output logic [DATA_W-1:0] rsp_rdata_out,
  output asz_pkg::asz_pins_t pins_out,
  input wire logic [DATA_W-1:0] dq_in
);
  // Counter must reach the longest phase; widths are fixed by the array
  if (ADDR_W != asz_pkg::ADDR_W || DATA_W != asz_pkg::DATA_W ||
    asz_pkg::ZERO_CYC > (1 << asz_pkg::CNT_W) || asz_pkg::READ_CYC > (1 << asz_pkg::CNT_W))
  begin : g_param_check
    $error("asz_host: parameters out of range for the 4096x4 array");
  end

  typedef enum logic [2:0] {ASZ_IDLE, ASZ_SETUP, ASZ_WPULSE, ASZ_WEND, ASZ_READ,
    ASZ_ZERO, ASZ_RECOVER} asz_state_t;

  asz_state_t state;
  logic [asz_pkg::CNT_W-1:0] cnt;
  asz_pkg::asz_req_t cur;
  logic [DATA_W-1:0] dq_sync;

  asz_sync #(.WIDTH(DATA_W)) u_sync (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .d_in(dq_in),
    .q_out(dq_sync)
  );

  // Sequencer: every op starts from deselect so address moves only with select high
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      state <= ASZ_IDLE;
      cnt <= '0;
      cur <= '0;
    end
    else
    begin
      unique case (state)
        ASZ_IDLE:
        begin
          if (req_valid_in)
          begin
            cur <= req_in;
            state <= ASZ_SETUP;
          end
        end
        ASZ_SETUP:
        begin
          // Address settled one cycle with select high
          cnt <= '0;
          unique case (cur.op)
            asz_pkg::ASZ_OP_WRITE: state <= ASZ_WPULSE;
            asz_pkg::ASZ_OP_ZERO: state <= ASZ_ZERO;
            default: state <= ASZ_READ;
          endcase
        end
        ASZ_WPULSE:
        begin
          cnt <= cnt + 1'b1;
          if (cnt == asz_pkg::CNT_W'(asz_pkg::WRITE_CYC - 1))
            state <= ASZ_WEND;
        end
        ASZ_WEND:
          state <= ASZ_IDLE;
        ASZ_READ:
        begin
          cnt <= cnt + 1'b1;
          if (cnt == asz_pkg::CNT_W'(asz_pkg::READ_CYC - 1))
            state <= ASZ_IDLE;
        end
        ASZ_ZERO:
        begin
          cnt <= cnt + 1'b1;
          if (cnt == asz_pkg::CNT_W'(asz_pkg::ZERO_CYC - 1))
          begin
            cnt <= '0;
            state <= ASZ_RECOVER;
          end
        end
        ASZ_RECOVER:
        begin
          cnt <= cnt + 1'b1;
          if (cnt == asz_pkg::CNT_W'(asz_pkg::RECOVER_CYC - 1))
            state <= ASZ_IDLE;
        end
        default: state <= ASZ_IDLE;
      endcase
    end
  end

  // Pin drive; strobes registered so outputs are glitch free
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      pins_out.chip_sel_n <= 1'b1;
      pins_out.write_n <= 1'b1;
      pins_out.out_drive_n <= 1'b1;
      pins_out.bulk_zero_req_n <= 1'b1;
      pins_out.addr <= '0;
      pins_out.dq_o <= '0;
      pins_out.dq_oe <= 1'b0;
    end
    else
    begin
      pins_out.chip_sel_n <= !(state == ASZ_SETUP || state == ASZ_WPULSE ||
        state == ASZ_READ || state == ASZ_ZERO);
      // Select and strobe fall together; write starts on the same edge as select
      pins_out.write_n <= !((state == ASZ_SETUP && cur.op == asz_pkg::ASZ_OP_WRITE) ||
        (state == ASZ_WPULSE && cnt != asz_pkg::CNT_W'(asz_pkg::WRITE_CYC - 1)));
      pins_out.out_drive_n <= !(state == ASZ_SETUP && cur.op == asz_pkg::ASZ_OP_READ ||
        state == ASZ_READ);
      pins_out.bulk_zero_req_n <= !((state == ASZ_SETUP && cur.op == asz_pkg::ASZ_OP_ZERO) ||
        (state == ASZ_ZERO && cnt != asz_pkg::CNT_W'(asz_pkg::ZERO_CYC - 1)));
      if (state == ASZ_IDLE && req_valid_in)
        pins_out.addr <= req_in.addr;
      pins_out.dq_o <= cur.wdata;
      // Drive data only in writes, never while output drive is low
      pins_out.dq_oe <= (state == ASZ_SETUP && cur.op == asz_pkg::ASZ_OP_WRITE) ||
        state == ASZ_WPULSE;
    end
  end

  // Request and answer handshake
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      req_ready_out <= 1'b0;
      rsp_valid_out <= 1'b0;
      rsp_rdata_out <= '0;
    end
    else
    begin
      req_ready_out <= (state == ASZ_IDLE) && !req_valid_in;
      rsp_valid_out <= (state == ASZ_READ && cnt == asz_pkg::CNT_W'(asz_pkg::READ_CYC - 1)) ||
        state == ASZ_WEND || (state == ASZ_RECOVER &&
        cnt == asz_pkg::CNT_W'(asz_pkg::RECOVER_CYC - 1));
      if (state == ASZ_READ && cnt == asz_pkg::CNT_W'(asz_pkg::READ_CYC - 1))
        rsp_rdata_out <= dq_sync;
    end
  end

  // Checks
  logic [7:0] zero_run;
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
      zero_run <= '0;
    else if (!pins_out.chip_sel_n && !pins_out.bulk_zero_req_n)
      zero_run <= zero_run + 1'b1;
    else
      zero_run <= '0;
  end

  sequence s_zero_held;
    !pins_out.bulk_zero_req_n && !pins_out.chip_sel_n;
  endsequence

  sequence s_zero_ends;
    pins_out.bulk_zero_req_n && !pins_out.chip_sel_n;
  endsequence

  a_addr_stable_sel: assert property (@(posedge clk_in) disable iff (!resetn_in)
    $changed(pins_out.addr) |-> $past(pins_out.chip_sel_n))
    else $error("address moved while selected");
  a_addr_write_hold: assert property (@(posedge clk_in) disable iff (!resetn_in)
    !pins_out.write_n |-> $stable(pins_out.addr))
    else $error("address moved during write");
  a_write_pulse_len: assert property (@(posedge clk_in) disable iff (!resetn_in)
    $fell(pins_out.write_n) |-> (!pins_out.write_n)[*4] ##1 pins_out.write_n)
    else $error("write pulse length wrong");
  a_write_in_select: assert property (@(posedge clk_in) disable iff (!resetn_in)
    !pins_out.write_n |-> !pins_out.chip_sel_n && pins_out.dq_oe)
    else $error("write strobe without select or data");
  a_no_contention: assert property (@(posedge clk_in) disable iff (!resetn_in)
    !pins_out.out_drive_n |-> !pins_out.dq_oe)
    else $error("bus contention");
  a_zero_cycle_len: assert property (@(posedge clk_in) disable iff (!resetn_in)
    $rose(pins_out.bulk_zero_req_n) && !pins_out.chip_sel_n |->
    zero_run == 8'(asz_pkg::ZERO_CYC))
    else $error("bulk-zero too short or long");
  a_zero_sel_hold: assert property (@(posedge clk_in) disable iff (!resetn_in)
    s_zero_held ##1 s_zero_ends |-> ##1 pins_out.chip_sel_n)
    else $error("select not released after zero");
  a_zero_needs_sel: assert property (@(posedge clk_in) disable iff (!resetn_in)
    !pins_out.bulk_zero_req_n |-> !pins_out.chip_sel_n)
    else $error("zero request while deselected");
endmodule : asz_host

// ==== src/asz_pkg.sv ====
// Package for the async SRAM host controller with bulk-zero support.
// Assumes a 100 MHz clk_in; all times below except DATA_SETUP_NS are converted to cycles here.
package asz_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 4;
  // Slowest grade figures, so any speed grade is met
  localparam int unsigned WRITE_PULSE_NS = 40;
  localparam int unsigned DATA_SETUP_NS = 18;
  localparam int unsigned READ_ACCESS_NS = 45;
  localparam int unsigned WRITE_TO_FLOAT_DELAY_NS = 15;
  localparam int unsigned BULK_ZERO_CYCLE_TIME_NS = 90;
  localparam int unsigned SELECT_LOW_TO_ZERO_END_NS = 90;
  localparam int unsigned ZERO_END_TO_INPUT_ACCEPT_NS = 0;
  // Least times round up, never below one cycle
  localparam int unsigned WRITE_CYC =
    (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned READ_CYC =
    (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam int unsigned FLOAT_CYC =
    (WRITE_TO_FLOAT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ZERO_CYC_A =
    (BULK_ZERO_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ZERO_CYC_B =
    (SELECT_LOW_TO_ZERO_END_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ZERO_CYC = (ZERO_CYC_A > ZERO_CYC_B) ? ZERO_CYC_A : ZERO_CYC_B;
  localparam int unsigned RECOVER_CYC =
    (ZERO_END_TO_INPUT_ACCEPT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam int unsigned CNT_W = 4;

  typedef enum logic [1:0] {ASZ_OP_READ, ASZ_OP_WRITE, ASZ_OP_ZERO} asz_op_t;

  typedef struct packed {
    asz_op_t op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } asz_req_t;

  typedef struct packed {
    logic chip_sel_n;
    logic write_n;
    logic out_drive_n;
    logic bulk_zero_req_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_o;
    logic dq_oe;
  } asz_pins_t;
endpackage : asz_pkg

// ==== src/asz_sync.sv ====
// Two-flop synchroniser for the data lines read back from the RAM.
// Assumes d_in is asynchronous to clk_in.
`timescale 1ns/1ps
module asz_sync #(
  parameter int unsigned WIDTH = 4
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      meta <= '0;
      q_out <= '0;
    end
    else
    begin
      meta <= d_in;
      q_out <= meta;
    end
  end
endmodule : asz_sync

// ==== test/asz_sram_model.sv ====
// Behavioural 4096x4 asynchronous RAM with bulk-zero input.
// Assumes the host's registered pins; no pin delays are modelled.
`timescale 1ns/1ps
module asz_sram_model (
  input wire asz_pkg::asz_pins_t pins_in,
  output logic [3:0] dq_out,
  output logic dq_oe_out
);
  logic [3:0] mem [0:4095];
  logic [3:0] last = 4'h0;
  logic [11:0] wr_addr = 12'h000;
  logic [3:0] wr_data = 4'h0;
  logic wr_on = 1'b0;
  always @(pins_in)
  begin
    if (!pins_in.chip_sel_n && !pins_in.write_n)
    begin
      wr_on = 1'b1;
      wr_addr = pins_in.addr;
      // Undriven data is stored as unknown so a missing drive shows up
      wr_data = pins_in.dq_oe ? pins_in.dq_o : 4'bxxxx;
    end
    else if (wr_on)
    begin
      wr_on = 1'b0;
      mem[wr_addr] = wr_data;
    end
    if (!pins_in.chip_sel_n && !pins_in.bulk_zero_req_n)
      foreach (mem[i]) mem[i] = 4'h0;
  end
  assign dq_oe_out = !pins_in.chip_sel_n && pins_in.write_n && !pins_in.out_drive_n;
  // Released lines show the inverse of the last driven change; a read equal to the released value leaves a stale copy
  always_comb dq_out = dq_oe_out ? mem[pins_in.addr] : ~last;
  always @(dq_out)
    if (dq_oe_out) last = dq_out;
endmodule : asz_sram_model

// ==== test/tb.sv ====
// Testbench for the bulk-zero RAM host: requests in, RAM model on the pins.
// Assumes asz_sram_model answers the pins with no delay.
`timescale 1ns/1ps
module tb;
  localparam logic [11:0] ADDRS [5] = '{12'h000, 12'hfff, 12'h5a5, 12'h001, 12'h800};
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic req_valid = 1'b0;
  asz_pkg::asz_req_t req = '0;
  logic req_ready;
  logic rsp_valid;
  logic [3:0] rdata;
  logic [3:0] m_dq;
  logic m_oe;
  logic [3:0] dq_bus;
  asz_pkg::asz_pins_t pins;
  int num_errors = 0;
  int n_checks = 0;
  int wr_len = 0;
  int zero_len = 0;
  logic prev_wr = 1'b0;
  logic prev_zero = 1'b0;
  logic [11:0] prev_addr = 12'h000;
  logic wr_now;
  logic zero_now;
  always #5 clk_in = ~clk_in;
  assign dq_bus = pins.dq_oe ? pins.dq_o : m_dq;
  assign wr_now = !pins.chip_sel_n && !pins.write_n;
  assign zero_now = !pins.chip_sel_n && !pins.bulk_zero_req_n;
  asz_host i_asz_host (.clk_in(clk_in), .resetn_in(resetn_in), .req_valid_in(req_valid),
    .req_in(req), .req_ready_out(req_ready), .rsp_valid_out(rsp_valid),
    .rsp_rdata_out(rdata), .pins_out(pins), .dq_in(dq_bus));
  asz_sram_model i_asz_sram_model (.pins_in(pins), .dq_out(m_dq), .dq_oe_out(m_oe));
  task automatic complete_run();
    if (num_errors == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run
  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Holds valid until the answer, then drops it a cycle before the next take
  task automatic do_op(input asz_pkg::asz_op_t op, input logic [11:0] a, input logic [3:0] d,
    input int lat);
    int k;
    @(posedge clk_in);
    #1;
    check("ready", {11'h0, req_ready}, 12'h1);
    req.op = op;
    req.addr = a;
    req.wdata = d;
    req_valid = 1'b1;
    k = 0;
    do
    begin
      @(posedge clk_in);
      #1;
      k++;
    end while (rsp_valid !== 1'b1 && k < 40);
    req_valid = 1'b0;
    if (k >= 40)
    begin
      num_errors++;
      complete_run();
    end
    check("latency", 12'(k - 1), 12'(lat));
  endtask : do_op
  always @(posedge clk_in)
  begin
    if (resetn_in)
    begin
      check("contention", {11'h0, pins.dq_oe & m_oe}, 12'h0);
      if (wr_now && prev_wr)
        check("write_addr", pins.addr, prev_addr);
      if (!wr_now && prev_wr)
        check("write_len", {11'h0, wr_len >= asz_pkg::WRITE_CYC}, 12'h1);
      if (!zero_now && prev_zero)
        check("zero_len", {11'h0, zero_len >= asz_pkg::ZERO_CYC}, 12'h1);
    end
    wr_len = wr_now ? wr_len + 1 : 0;
    zero_len = zero_now ? zero_len + 1 : 0;
    prev_wr = wr_now;
    prev_zero = zero_now;
    prev_addr = pins.addr;
  end
  task automatic t_idle();
    check("idle_pins", {8'h0, pins.chip_sel_n, pins.write_n, pins.dq_oe, m_oe}, 12'hc);
  endtask : t_idle
  task automatic t_write_read();
    for (int i = 0; i < 4; i++)
      do_op(asz_pkg::ASZ_OP_WRITE, ADDRS[i], 4'(i * 5 + 3), 6);
    for (int i = 0; i < 4; i++)
    begin
      do_op(asz_pkg::ASZ_OP_READ, ADDRS[i], 4'h0, 7);
      check("read_data", {8'h0, rdata}, {8'h0, 4'(i * 5 + 3)});
    end
  endtask : t_write_read
  task automatic t_zero();
    do_op(asz_pkg::ASZ_OP_ZERO, 12'h000, 4'h0, 11);
    for (int i = 0; i < 5; i++)
    begin
      do_op(asz_pkg::ASZ_OP_READ, ADDRS[i], 4'h0, 7);
      check("zero_data", {8'h0, rdata}, 12'h0);
    end
    do_op(asz_pkg::ASZ_OP_WRITE, 12'h5a5, 4'h9, 6);
    do_op(asz_pkg::ASZ_OP_READ, 12'h5a5, 4'h0, 7);
    check("after_zero", {8'h0, rdata}, 12'h9);
  endtask : t_zero
  initial
  begin
    repeat (10) @(posedge clk_in);
    #1;
    resetn_in = 1'b1;
    t_idle();
    t_write_read();
    t_zero();
    complete_run();
  end
endmodule : tb
